// *** logic/jdr_defs.svh ***
// Purpose: Constants for the scan data registers
// Assumes: Included by its bare name
// Notes:   Codes, field positions, reset values and sizes
`ifndef JDR_DEFS_SVH
`define JDR_DEFS_SVH
// ----------------------------------------------------
// Instruction codes
// ----------------------------------------------------
`define JDR_IR_W        5
`define JDR_IR_EXTEST   5'h00
`define JDR_IR_SAMPLE   5'h01
`define JDR_IR_CLAMP    5'h04
`define JDR_IR_FLOAT    5'h05
`define JDR_IR_IDENT    5'h0c
`define JDR_IR_BYPASS   5'h1f
// ----------------------------------------------------
// Identification layout
// ----------------------------------------------------
`define JDR_ID_W        32
`define JDR_ID_VER_LSB  28
`define JDR_ID_PART_LSB 12
`define JDR_ID_MFR_LSB  1
`define JDR_ID_FIXED    1'b1
// ----------------------------------------------------
// Chain and buffer sizes, reset values
// ----------------------------------------------------
`define JDR_BSR_LEN     141
`define JDR_STRAP_LO    46
`define JDR_STRAP_HI    47
`define JDR_LONE_CELL   94
`define JDR_FIFO_DEPTH  32
`define JDR_BYP_CAPT    1'b0
`define JDR_TDO_RST     1'b0
`endif

// *** logic/jdr_pkg.sv ***
// Purpose: Types shared by the scan data registers
// Assumes: Nothing
// Notes:   Codes live in jdr_defs.svh
package jdr_pkg;
  typedef enum logic [1:0] {
    JDR_SEL_BYP,
    JDR_SEL_ID,
    JDR_SEL_BSR
  } jdr_sel_t;
  typedef enum logic [1:0] {
    JDR_CELL_TWO_WAY,
    JDR_CELL_CTRL,
    JDR_CELL_INPUT
  } jdr_cell_t;
endpackage : jdr_pkg

// *** logic/jdr_data_regs.sv ***
// Purpose: Bypass, identification and boundary chain of the TAP
// Assumes: Tap controller on CLK gives instruction and DR state
// Notes:   TCK/TDI/pin captures are sampled pins, synced twice
`timescale 1ns/1ps
`include "jdr_defs.svh"

// ----------------------------------------------------
// Bit FIFO between shift and TDO launch
// ----------------------------------------------------
module jdr_fifo #(
  parameter int W = 1,
  parameter int D = `JDR_FIFO_DEPTH
) (
  input  wire logic         clk,      // System clock
  input  wire logic         rst,      // Async reset, high
  input  wire logic         in_valid, // Write request
  output logic              in_ready, // Not full
  input  wire logic [W-1:0] in_data,  // Write data
  output logic              out_valid,// Not empty
  input  wire logic         out_ready,// Read request
  output logic      [W-1:0] out_data  // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          wr, rd;

  always_comb begin
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    wp_d = wr ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = rd ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (wr && !rd) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (rd && !wr) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (wr) begin
      mem_q[wp_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
endmodule : jdr_fifo

// Notes on behaviour
// - Bypass instructions put one shift stage between TDI and TDO.
// - Bypass is the path whenever no test operation is selected.
// - 32-bit read-only ID: version in 31:28, part number in 27:12.
// - ID bits 11:1 carry the fixed maker identifier.
// - ID bit 0 always reads one.
// - Boundary chain shifts serially from TDI toward TDO.
// - Chain covers signal pins only, not power, ground or TAP pins.
// - Cells come in kinds: two-way data, input only, control.
// - Chain cells disturb normal pin operation only under external test and clamp.
// - Sample and external test capture pins and drivers in parallel.
// - Parallel capture happens on rising TCK.
// - Cell 0 is a two-way cell, cell 1 its control; straps lack one.
// - Undefined codes act exactly as the all-ones bypass code.
// - Code 01100 selects the identification register.
// - Codes 00001 and 00000 select the boundary chain.
// - Code 00101 floats outputs and shifts through bypass.
module jdr_data_regs
  import jdr_pkg::*;
#(
  parameter logic [3:0]  VERSION = 4'h1,    // Arbitrary value
  parameter logic [15:0] PART    = 16'h5a5a,// Arbitrary value
  parameter logic [10:0] MAKER   = 11'h0aa  // Arbitrary value
) (
  input  wire logic                    CLK,      // 50 MHz clock
  input  wire logic                    RST,      // Async reset
  input  wire logic                    TCK,      // Test clock pin
  input  wire logic                    TDI,      // Test data in pin
  input  wire logic [`JDR_IR_W-1:0]    IR_CODE,  // Active code
  input  wire logic                    DR_CAPTURE,// Capture-DR
  input  wire logic                    DR_SHIFT, // Shift-DR
  input  wire logic                    DR_UPDATE,// Update-DR
  input  wire logic [`JDR_BSR_LEN-1:0] PIN_CAP,  // Pin/driver levels
  output logic                         TDO,      // Test data out
  output logic                         TDO_OE_N, // TDO enable, low
  output logic [`JDR_BSR_LEN-1:0]      BSR_UPD,  // Update latches
  output logic                         TEST_DRIVE,// Pins from chain
  output logic                         FLOAT_PINS // Pins floated
);
  localparam int N = `JDR_BSR_LEN;
  localparam logic [`JDR_ID_W-1:0] ID_VALUE = {
    VERSION, PART, MAKER, `JDR_ID_FIXED};

  // ----------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------
  logic         tck_m_q, tck_s_q, tck_p_q;
  logic         tdi_m_q, tdi_s_q;
  logic [N-1:0] cap_m_q, cap_s_q;
  logic         tck_rise, tck_fall;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tck_m_q <= 1'b0;
      tck_s_q <= 1'b0;
      tck_p_q <= 1'b0;
      tdi_m_q <= 1'b0;
      tdi_s_q <= 1'b0;
      cap_m_q <= '0;
      cap_s_q <= '0;
    end else begin
      tck_m_q <= TCK;
      tck_s_q <= tck_m_q;
      tck_p_q <= tck_s_q;
      tdi_m_q <= TDI;
      tdi_s_q <= tdi_m_q;
      cap_m_q <= PIN_CAP;
      cap_s_q <= cap_m_q;
    end
  end

  // Edge pulses run at the TCK rate as one-cycle enables
  assign tck_rise = tck_s_q && !tck_p_q;
  assign tck_fall = !tck_s_q && tck_p_q;

  // ----------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------
  jdr_sel_t sel;
  logic     bsr_op;

  always_comb begin
    bsr_op = (IR_CODE == `JDR_IR_SAMPLE) ||
             (IR_CODE == `JDR_IR_EXTEST);
    if (bsr_op) begin
      sel = JDR_SEL_BSR;
    end else if (IR_CODE == `JDR_IR_IDENT) begin
      sel = JDR_SEL_ID;
    end else begin
      // Float, clamp, bypass and every undefined code
      sel = JDR_SEL_BYP;
    end
  end

  // ----------------------------------------------------
  // Cell kinds along the chain
  // ----------------------------------------------------
  // Data cells even up to the lone cell that shares its control; odd above
  jdr_cell_t    kind [N];
  logic [N-1:0] upd_mask;

  for (genvar i = 0; i < N; i++) begin : g_cell
    if (i == `JDR_STRAP_LO || i == `JDR_STRAP_HI) begin : g_in
      assign kind[i] = JDR_CELL_INPUT;
    end else if (i <= `JDR_LONE_CELL ? i % 2 == 1 : i % 2 == 0) begin : g_ct
      assign kind[i] = JDR_CELL_CTRL;
    end else begin : g_tw
      assign kind[i] = JDR_CELL_TWO_WAY;
    end
    // Input cells only observe, so they own no update latch
    assign upd_mask[i] = (kind[i] != JDR_CELL_INPUT);
  end

  // ----------------------------------------------------
  // Shift paths
  // ----------------------------------------------------
  logic                 byp_q, byp_d;
  logic [`JDR_ID_W-1:0] id_q, id_d;
  logic [N-1:0]         bsr_q, bsr_d;
  logic [N-1:0]         upd_q, upd_d;
  logic                 push, push_bit, f_ready;
  logic                 f_valid, f_bit;

  // A full buffer holds the shift back rather than drop a bit
  assign push = tck_rise && DR_SHIFT && f_ready;

  always_comb begin
    byp_d    = byp_q;
    id_d     = id_q;
    bsr_d    = bsr_q;
    upd_d    = upd_q;
    push_bit = 1'b0;
    unique case (sel)
      JDR_SEL_BYP: push_bit = byp_q;
      JDR_SEL_ID:  push_bit = id_q[0];
      JDR_SEL_BSR: push_bit = bsr_q[0];
    endcase
    if (tck_rise && DR_CAPTURE) begin
      unique case (sel)
        JDR_SEL_BYP: byp_d = `JDR_BYP_CAPT;
        JDR_SEL_ID:  id_d  = ID_VALUE;
        JDR_SEL_BSR: bsr_d = cap_s_q;
      endcase
    end else if (push) begin
      unique case (sel)
        JDR_SEL_BYP: byp_d = tdi_s_q;
        JDR_SEL_ID:  id_d  = {tdi_s_q, id_q[`JDR_ID_W-1:1]};
        JDR_SEL_BSR: bsr_d = {tdi_s_q, bsr_q[N-1:1]};
      endcase
    end
    if (tck_rise && DR_UPDATE && sel == JDR_SEL_BSR) begin
      upd_d = bsr_q & upd_mask;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      byp_q <= 1'b0;
      id_q  <= '0;
      bsr_q <= '0;
      upd_q <= '0;
    end else begin
      byp_q <= byp_d;
      id_q  <= id_d;
      bsr_q <= bsr_d;
      upd_q <= upd_d;
    end
  end

  jdr_fifo #(
    .W (1),
    .D (`JDR_FIFO_DEPTH)
  ) i_jdr_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (push_bit),
    .out_valid (f_valid),
    .out_ready (tck_fall),
    .out_data  (f_bit)
  );

  // ----------------------------------------------------
  // Outputs
  // ----------------------------------------------------
  logic tdo_q, tdo_d, oe_n_q, oe_n_d;
  logic drive_q, drive_d, float_q, float_d;

  always_comb begin
    tdo_d  = tdo_q;
    oe_n_d = oe_n_q;
    if (tck_fall) begin
      tdo_d  = f_valid ? f_bit : tdo_q;
      oe_n_d = !f_valid;
    end
    // Chain reaches the pins only through these flags
    drive_d = (IR_CODE == `JDR_IR_EXTEST) ||
              (IR_CODE == `JDR_IR_CLAMP);
    float_d = (IR_CODE == `JDR_IR_FLOAT);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tdo_q   <= `JDR_TDO_RST;
      oe_n_q  <= 1'b1;
      drive_q <= 1'b0;
      float_q <= 1'b0;
    end else begin
      tdo_q   <= tdo_d;
      oe_n_q  <= oe_n_d;
      drive_q <= drive_d;
      float_q <= float_d;
    end
  end

  assign TDO        = tdo_q;
  assign TDO_OE_N   = oe_n_q;
  assign BSR_UPD    = upd_q;
  assign TEST_DRIVE = drive_q;
  assign FLOAT_PINS = float_q;

  // ----------------------------------------------------
  // Checks
  // ----------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_undef_bypass: assert property (
    !(IR_CODE inside {`JDR_IR_EXTEST, `JDR_IR_SAMPLE,
      `JDR_IR_IDENT}) |-> sel == JDR_SEL_BYP)
    else $error("undefined code left bypass");
  chk_ident_select: assert property (
    IR_CODE == `JDR_IR_IDENT |-> sel == JDR_SEL_ID)
    else $error("ident code did not select id");
  chk_bypass_capture: assert property (
    tck_rise && DR_CAPTURE && sel == JDR_SEL_BYP |=> !byp_q)
    else $error("bypass stage not cleared on capture");
  chk_id_capture: assert property (
    tck_rise && DR_CAPTURE && sel == JDR_SEL_ID
    |=> id_q == {VERSION, PART, MAKER, 1'b1})
    else $error("id value wrong after capture");
  chk_id_fixed_bit: assert property (
    tck_rise && DR_CAPTURE && sel == JDR_SEL_ID |=> id_q[0])
    else $error("id bit 0 not one");
  chk_bsr_capture: assert property (
    tck_rise && DR_CAPTURE && sel == JDR_SEL_BSR
    |=> bsr_q == $past(cap_s_q))
    else $error("chain missed parallel capture");
  chk_bsr_shift: assert property (
    push && !DR_CAPTURE && sel == JDR_SEL_BSR
    |=> bsr_q[N-1] == $past(tdi_s_q) &&
        bsr_q[N-2:0] == $past(bsr_q[N-1:1]))
    else $error("chain shift wrong");
  chk_tdo_launch: assert property (
    tck_fall && f_valid |=> TDO == $past(f_bit) && !TDO_OE_N)
    else $error("tdo not launched on falling tck");
  chk_float_flag: assert property (
    IR_CODE == `JDR_IR_FLOAT |=> FLOAT_PINS && !TEST_DRIVE)
    else $error("float flag wrong");
  chk_strap_no_upd: assert property (
    tck_rise && DR_UPDATE |=> !BSR_UPD[`JDR_STRAP_LO] &&
    !BSR_UPD[`JDR_STRAP_HI])
    else $error("strap cell got update latch");

  cov_id_shift: cover property (
    sel == JDR_SEL_ID && push ##[1:200] tck_fall && f_valid);
  cov_bsr_update: cover property (
    tck_rise && DR_UPDATE && sel == JDR_SEL_BSR);
  cov_bypass_shift: cover property (
    sel == JDR_SEL_BYP && push);
endmodule : jdr_data_regs

// *** test/jdr_tester.sv ***
// Purpose: Boundary-scan tester model on the far side of the port
// Assumes: TCK at 160 ns, launched and released on CLK rising edges
// Notes:   TCK stands low between frames
`timescale 1ns/1ps

module jdr_tester (
  input  wire logic CLK, // Bench clock
  input  wire logic TDO, // Serial data from the device
  output logic      TCK, // Test clock pin
  output logic      TDI  // Test data pin
);
  initial begin
    TCK = 1'b0;
    TDI = 1'b0;
  end

  // ----------------------------------------------------
  // One TCK period: low 80 ns, then high 80 ns
  // ----------------------------------------------------
  // Sampling at the end of the high phase leaves the device a full
  // low phase plus the high phase to launch its bit after a fall.
  task automatic cyc(input logic b, output logic o);
    repeat (4) @(posedge CLK);
    TCK <= 1'b1;
    TDI <= b;
    repeat (4) @(posedge CLK);
    o = TDO;
    TCK <= 1'b0;
    TDI <= ~b;    // Stale data is not repeated after the hold
  endtask : cyc
endmodule : jdr_tester

// *** test/jdr_data_regs_test.sv ***
// Purpose: Self-checking bench for the scan data registers
// Assumes: Bench acts as the TAP controller on CLK
// Notes:   Expected values come from bench constants only
`timescale 1ns/1ps
`include "jdr_defs.svh"

module jdr_data_regs_test;
  localparam logic [3:0]  VER = 4'h6;    // Arbitrary value
  localparam logic [15:0] PRT = 16'h3c3c;// Arbitrary value
  localparam logic [10:0] MKR = 11'h155; // Arbitrary value

  logic         clk  = 1'b0;
  logic         rst  = 1'b1;
  logic         cap  = 1'b0;
  logic         shf  = 1'b0;
  logic         upd  = 1'b0;
  logic [4:0]   ir   = `JDR_IR_BYPASS;
  logic [140:0] pins = '0;
  logic         tck, tdi, tdo, tdo_oe_n, test_drive, float_pins;
  logic [140:0] bsr_upd;
  int           n_mismatch = 0;
  int           total_checks = 0;

  always #10 clk = ~clk;

  jdr_data_regs #(.VERSION(VER), .PART(PRT), .MAKER(MKR)) i_jdr_data_regs (
    .CLK(clk), .RST(rst), .TCK(tck), .TDI(tdi), .IR_CODE(ir),
    .DR_CAPTURE(cap), .DR_SHIFT(shf), .DR_UPDATE(upd), .PIN_CAP(pins),
    .TDO(tdo), .TDO_OE_N(tdo_oe_n), .BSR_UPD(bsr_upd),
    .TEST_DRIVE(test_drive), .FLOAT_PINS(float_pins));

  jdr_tester i_jdr_tester (.CLK(clk), .TDO(tdo), .TCK(tck), .TDI(tdi));

  // ----------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------
  task automatic chk(input string what, input logic [140:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Capture, n shifts, then an update period that collects the last bit
  task automatic frame(input logic [4:0] code, input int n,
                       input logic [140:0] din, output logic [140:0] dout);
    logic b;
    dout = '0;
    ir  <= code;
    cap <= 1'b1;
    i_jdr_tester.cyc(1'b0, b);
    chk("tdo_oe_n idle", 1'b1, tdo_oe_n);
    cap <= 1'b0;
    shf <= 1'b1;
    for (int k = 0; k < n; k++) begin
      i_jdr_tester.cyc(din[k], b);
      if (k > 0) dout[k-1] = b;
    end
    shf <= 1'b0;
    upd <= 1'b1;
    i_jdr_tester.cyc(1'b0, b);
    dout[n-1] = b;
    chk("tdo_oe_n shifting", 1'b0, tdo_oe_n);
    upd <= 1'b0;
  endtask : frame

  // ----------------------------------------------------
  // Scenarios
  // ----------------------------------------------------
  task automatic t_reset;
    chk("tdo", `JDR_TDO_RST, tdo);
    chk("tdo_oe_n", 1'b1, tdo_oe_n);
    chk("bsr_upd", '0, bsr_upd);
  endtask : t_reset

  task automatic t_ident;
    logic [140:0] d;
    frame(`JDR_IR_IDENT, 32, '0, d);
    chk("id version", VER, d[31:28]);
    chk("id part", PRT, d[27:12]);
    chk("id maker", MKR, d[11:1]);
    chk("id fixed", `JDR_ID_FIXED, d[0]);
  endtask : t_ident

  task automatic t_bypass(input logic [4:0] code, input logic drv, flt);
    logic [140:0] din;
    logic [140:0] d;
    din = 141'h5b;
    frame(code, 8, din, d);
    chk("bypass path", {din[6:0], `JDR_BYP_CAPT}, d[7:0]);
    chk("test_drive", drv, test_drive);
    chk("float_pins", flt, float_pins);
  endtask : t_bypass

  task automatic t_chain(input logic [4:0] code, input logic [140:0] p, din);
    logic [140:0] d;
    logic [140:0] exp;
    pins <= p;
    frame(code, `JDR_BSR_LEN, din, d);
    chk("chain capture", p, d);
    exp = din;
    exp[`JDR_STRAP_HI:`JDR_STRAP_LO] = 2'b00;
    chk("chain update", exp, bsr_upd);
    chk("test_drive", code == `JDR_IR_EXTEST, test_drive);
  endtask : t_chain

  // ----------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bypass(`JDR_IR_BYPASS, 1'b0, 1'b0);
    t_bypass(`JDR_IR_FLOAT, 1'b0, 1'b1);
    t_bypass(`JDR_IR_CLAMP, 1'b1, 1'b0);
    t_bypass(5'h02, 1'b0, 1'b0);
    t_bypass(5'h0a, 1'b0, 1'b0);
    t_ident();
    t_chain(`JDR_IR_SAMPLE, {47{3'b101}}, {47{3'b110}});
    t_chain(`JDR_IR_EXTEST, {47{3'b010}}, {47{3'b011}});
    test_done();
  end
endmodule : jdr_data_regs_test
